// ---- rtl/gsr_params.svh ----
`ifndef GSR_PARAMS_SVH
`define GSR_PARAMS_SVH

// Clock rate in hertz.
`define GSR_CLK_HZ 64'd10000000
// Clear-field gating timeout in milliseconds, normal mode; short mode uses the 3700 ms value below.
`define GSR_CLEAR_TIMEOUT_MS 64'd4000
`define GSR_CLEAR_TIMEOUT_SHORT_MS 64'd3700
// Restart window limit in seconds.
`define GSR_RESTART_WINDOW_S 64'd3600
// Derived cycle counts.
`define GSR_CLEAR_TIMEOUT_CYC (`GSR_CLEAR_TIMEOUT_MS * `GSR_CLK_HZ / 64'd1000)
`define GSR_CLEAR_TIMEOUT_SHORT_CYC (`GSR_CLEAR_TIMEOUT_SHORT_MS * `GSR_CLK_HZ / 64'd1000)
`define GSR_RESTART_WINDOW_CYC (`GSR_RESTART_WINDOW_S * `GSR_CLK_HZ)

`endif

// ---- rtl/gsr_pkg.sv ----
package gsr_pkg;

  typedef enum logic [1:0] {
    GSR_ST_IDLE,
    GSR_ST_GATING,
    GSR_ST_PROTECT,
    GSR_ST_INTERLOCK
  } gsr_state_e;

endpackage

// ---- rtl/gsr_gating_sequence_reset.sv ----
`timescale 1ns/1ps
`include "gsr_params.svh"

module gsr_gating_sequence_reset #(
  parameter logic [35:0] CLEAR_TIMEOUT_CYC = 36'(`GSR_CLEAR_TIMEOUT_CYC),
  parameter logic [35:0] CLEAR_TIMEOUT_SHORT_CYC = 36'(`GSR_CLEAR_TIMEOUT_SHORT_CYC),
  parameter logic [35:0] RESTART_WINDOW_CYC = 36'(`GSR_RESTART_WINDOW_CYC)
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic gating_start_i,
  input wire logic restart_button_input_i,
  input wire logic field_interrupted_flag_i,
  input wire logic short_timeout_mode_i,
  output logic safety_outputs_o,
  output logic gating_active_indication_o,
  output logic protective_mode_o,
  output logic interlock_o
);
  import gsr_pkg::*;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Counter step that saturates, so a stuck state can never wrap back to a short count.
  function automatic logic [35:0] cnt_step(input logic [35:0] value);
    logic [35:0] next_value;
    next_value = value;
    if (value != 36'hf_ffff_ffff) begin
      next_value = value + 36'h1;
    end
    return next_value;
  endfunction

  // Safety outputs stay on only while idle or timing a clear-field gating sequence.
  function automatic logic outs_enabled(input gsr_state_e state);
    return (state == GSR_ST_IDLE) || (state == GSR_ST_GATING);
  endfunction

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic btn_prev_q;
  logic cs_prev_q;

  wire [3:0] pins_raw = {short_timeout_mode_i, field_interrupted_flag_i, restart_button_input_i, gating_start_i};

  // The first stage may go metastable, so only the second stage is read by logic.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1_q <= 4'h0;
    end else begin
      sync1_q <= pins_raw;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync2_q <= 4'h0;
    end else begin
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      btn_prev_q <= 1'b0;
    end else begin
      btn_prev_q <= sync2_q[1];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cs_prev_q <= 1'b0;
    end else begin
      cs_prev_q <= sync2_q[0];
    end
  end

  wire cs = sync2_q[0];
  wire field_int = sync2_q[2];
  wire short_mode = sync2_q[3];
  // A restart is taken on the button's release edge.
  wire btn_release = btn_prev_q & ~sync2_q[1];
  // Gating start asserts on a rising edge, from the low to the active level.
  wire cs_rise = cs & ~cs_prev_q;

  // ==========================================================================
  // Sequence control
  // ==========================================================================
  gsr_state_e state_q;
  gsr_state_e state_d;
  logic [35:0] cnt_q;
  logic [35:0] cnt_d;
  logic need_rearm_q;
  logic need_rearm_d;

  wire [35:0] clear_limit = short_mode ? CLEAR_TIMEOUT_SHORT_CYC : CLEAR_TIMEOUT_CYC;
  wire clear_expired = (cnt_q >= clear_limit);
  wire window_expired = (cnt_q >= RESTART_WINDOW_CYC);
  wire [35:0] cnt_inc = cnt_step(cnt_q);

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    need_rearm_d = need_rearm_q;
    if (cs_rise) begin
      need_rearm_d = 1'b0;
    end
    case (state_q)
      GSR_ST_IDLE: begin
        cnt_d = 36'h0;
        // An interrupted field belongs to normal gating, so the clear-field timer waits for a clear field.
        if (cs && !field_int && !need_rearm_q) begin
          state_d = GSR_ST_GATING;
        end
      end
      GSR_ST_GATING: begin
        if (!cs || field_int) begin
          // Field interruption hands over to normal gating, outside this block.
          state_d = GSR_ST_IDLE;
          cnt_d = 36'h0;
        end else if (clear_expired) begin
          state_d = GSR_ST_PROTECT;
          cnt_d = 36'h0;
        end else begin
          cnt_d = cnt_inc[35:0];
        end
      end
      GSR_ST_PROTECT: begin
        if (field_int) begin
          state_d = GSR_ST_INTERLOCK;
        end else if (btn_release) begin
          // Re-entering gating restarts the clear-field timer, so this repeats freely.
          state_d = GSR_ST_GATING;
          cnt_d = 36'h0;
          need_rearm_d = 1'b0;
        end else if (window_expired) begin
          state_d = GSR_ST_INTERLOCK;
        end else begin
          cnt_d = cnt_inc[35:0];
        end
      end
      GSR_ST_INTERLOCK: begin
        // Leaving interlock needs a restart button release with a clear field; gating then needs a fresh gating start edge.
        cnt_d = 36'h0;
        if (btn_release && !field_int) begin
          state_d = GSR_ST_IDLE;
          need_rearm_d = 1'b1;
        end
      end
      default: begin
        state_d = GSR_ST_INTERLOCK;
        cnt_d = 36'h0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= GSR_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= 36'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      need_rearm_q <= 1'b0;
    end else begin
      need_rearm_q <= need_rearm_d;
    end
  end

  // ==========================================================================
  // Registered outputs
  // ==========================================================================
  wire safe_on_d = outs_enabled(state_d);
  wire gating_on_d = (state_d == GSR_ST_GATING);
  wire protect_on_d = (state_d == GSR_ST_PROTECT);
  wire interlock_on_d = (state_d == GSR_ST_INTERLOCK);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      safety_outputs_o <= 1'b0;
    end else begin
      safety_outputs_o <= safe_on_d;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gating_active_indication_o <= 1'b0;
    end else begin
      gating_active_indication_o <= gating_on_d;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      protective_mode_o <= 1'b0;
    end else begin
      protective_mode_o <= protect_on_d;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      interlock_o <= 1'b0;
    end else begin
      interlock_o <= interlock_on_d;
    end
  end

endmodule // gsr_gating_sequence_reset

// ---- tb/gsr_checker.sv ----
`timescale 1ns/1ps
module gsr_checker #(
  parameter logic [35:0] CLEAR_TIMEOUT_CYC = 36'h14,
  parameter logic [35:0] CLEAR_TIMEOUT_SHORT_CYC = 36'hf,
  parameter logic [35:0] RESTART_WINDOW_CYC = 36'h64
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic gating_start_i,
  input wire logic restart_button_input_i,
  input wire logic field_interrupted_flag_i,
  input wire logic short_timeout_mode_i,
  input wire logic safety_outputs_o,
  input wire logic gating_active_indication_o,
  input wire logic protective_mode_o,
  input wire logic interlock_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  logic [35:0] g_q, p_q;
  wire [35:0] clear_lim = short_timeout_mode_i ? CLEAR_TIMEOUT_SHORT_CYC : CLEAR_TIMEOUT_CYC;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) {g_q, p_q} <= '0;
    else {g_q, p_q} <= {gating_active_indication_o ? g_q + 36'h1 : 36'h0, protective_mode_o ? p_q + 36'h1 : 36'h0};
  end
  a_prot_outs_off: assert property (protective_mode_o |-> !safety_outputs_o && !gating_active_indication_o)
    else $error("outputs on in protective mode");
  a_lock_outs_off: assert property (interlock_o |-> !safety_outputs_o && !gating_active_indication_o)
    else $error("outputs on in interlock");
  a_prot_from_gate: assert property ($rose(protective_mode_o) |-> $past(gating_active_indication_o))
    else $error("protective mode not entered from gating");
  a_gate_time_span: assert property ($rose(protective_mode_o) |-> g_q + 2 >= clear_lim && g_q <= clear_lim + 2)
    else $error("gating timeout length off");
  a_restart_window_bound: assert property (p_q <= RESTART_WINDOW_CYC + 2)
    else $error("restart window overrun");
  a_restart_gates_on: assert property ($fell(protective_mode_o) && !interlock_o |-> gating_active_indication_o && safety_outputs_o)
    else $error("restart did not reopen gating");
  a_lock_from_prot: assert property ($rose(interlock_o) |-> $past(protective_mode_o))
    else $error("interlock not entered from protective mode");
  a_mode_excl: assert property (!(protective_mode_o && interlock_o))
    else $error("protective mode and interlock together");
  cover property ($rose(protective_mode_o));
  cover property ($fell(protective_mode_o) && gating_active_indication_o);
  cover property ($rose(interlock_o));
endmodule // gsr_checker

bind gsr_gating_sequence_reset gsr_checker #(.CLEAR_TIMEOUT_CYC(CLEAR_TIMEOUT_CYC),
  .CLEAR_TIMEOUT_SHORT_CYC(CLEAR_TIMEOUT_SHORT_CYC), .RESTART_WINDOW_CYC(RESTART_WINDOW_CYC)) gsr_checker_inst (.*);

// ---- tb/gsr_ctrl_model.sv ----
`timescale 1ns/1ps
module gsr_ctrl_model (
  input wire logic cs_req_i,
  input wire logic btn_req_i,
  input wire logic fld_req_i,
  output wire logic gating_start_o,
  output wire logic restart_button_o,
  output wire logic field_o
);
  // The control lifts gating start from low to active, and lowers it between sequences when asked.
  assign gating_start_o = cs_req_i;
  assign restart_button_o = btn_req_i;
  assign field_o = fld_req_i;
endmodule // gsr_ctrl_model

// ---- tb/gsr_gating_sequence_reset_bench.sv ----
`timescale 1ns/1ps
module gsr_gating_sequence_reset_bench;
  logic clk_i = 0, arst_n_i = 0, cs_q = 0, btn_q = 0, fld_q = 0, mode_q = 0;
  wire gs, rb, fi, so, ga, pm, il;
  int n_fail = 0, comparisons = 0;
  always #50 clk_i = ~clk_i;
  gsr_ctrl_model gsr_ctrl_model_inst (.cs_req_i(cs_q), .btn_req_i(btn_q), .fld_req_i(fld_q),
    .gating_start_o(gs), .restart_button_o(rb), .field_o(fi));
  gsr_gating_sequence_reset #(.CLEAR_TIMEOUT_CYC(36'h14), .CLEAR_TIMEOUT_SHORT_CYC(36'hf),
    .RESTART_WINDOW_CYC(36'h64)) gsr_gating_sequence_reset_inst (.clk_i, .arst_n_i, .gating_start_i(gs),
    .restart_button_input_i(rb), .field_interrupted_flag_i(fi), .short_timeout_mode_i(mode_q),
    .safety_outputs_o(so), .gating_active_indication_o(ga), .protective_mode_o(pm), .interlock_o(il));
  function automatic int tmo(logic m);
    return m ? 15 : 20;
  endfunction
  task automatic w(int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Output codes in the order safety outputs, gating active, protective mode, interlock.
  localparam logic [3:0] IDLE_OUTS = 4'h8;
  localparam logic [3:0] GATE_OUTS = 4'hc;
  localparam logic [3:0] PROT_OUTS = 4'h2;
  localparam logic [3:0] LOCK_OUTS = 4'h1;
  function automatic logic [3:0] outs();
    return {so, ga, pm, il};
  endfunction
  task automatic chk(input string name, input logic [3:0] seen, input logic [3:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test;
    if (n_fail == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    void'($urandom(31925));
    w(16);
    arst_n_i = 1;
    w(2);
    chk("outputs", outs(), IDLE_OUTS);
    for (int m = 0; m < 2; m++) begin
      mode_q = m[0];
      cs_q = 1;
      w(tmo(m[0]) + 2);
      chk("outputs", outs(), GATE_OUTS);
      w(4);
      chk("outputs", outs(), PROT_OUTS);
      repeat (3) begin
        btn_q = 1;
        w($urandom_range(1, 4));
        chk("outputs", outs(), PROT_OUTS);
        btn_q = 0;
        w(8);
        chk("outputs", outs(), GATE_OUTS);
        w(tmo(m[0]) - 1);
        chk("outputs", outs(), PROT_OUTS);
      end
      if (m) begin
        fld_q = 1;
        w(8);
        chk("outputs", outs(), LOCK_OUTS);
        fld_q = 0;
      end else begin
        w(95);
        chk("outputs", outs(), PROT_OUTS);
        w(9);
        chk("outputs", outs(), LOCK_OUTS);
      end
      btn_q = 1;
      w(2);
      btn_q = 0;
      w(8);
      chk("outputs", outs(), IDLE_OUTS);
      cs_q = 0;
      w(6);
    end
    arst_n_i = 0;
    w(2);
    chk("outputs", outs(), 4'h0);
    arst_n_i = 1;
    w(2);
    chk("outputs", outs(), IDLE_OUTS);
    cs_q = 1;
    w(6);
    chk("outputs", outs(), GATE_OUTS);
    fld_q = 1;
    w(4);
    chk("outputs", outs(), IDLE_OUTS);
    fld_q = 0;
    cs_q = 0;
    w(2);
    finish_test;
  end
  initial begin
    w(20000);
    n_fail++;
    finish_test;
  end
endmodule // gsr_gating_sequence_reset_bench
